// ==== hdl/dhi_host_if.v ====
/*
 host interface of a 320x240 colour panel: parallel command bus,
 3/4-wire serial link and, in the parallel modes only, rgb pixel port, decoded into a word stream.
 assumes host pins are asynchronous to ref_clk_i and the pixel clock
 and serial clock are slow enough to be sampled at 250 MHz.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dhi_regs.vh"
module dhi_host_if (
  input  wire                   ref_clk_i,
  input  wire                   rstn_i,
  input  wire                   mode_sel_hi_i,
  input  wire                   mode_sel_mid_i,
  input  wire                   mode_sel_lo_i,
  input  wire                   cs_n_i,
  input  wire                   wr_n_i,
  input  wire                   rd_n_i,
  input  wire                   data_cmd_sel_i,
  input  wire                   serial_data_i,
  input  wire [`DHI_BUS_W-1:0]  host_data_bus_i,
  output wire [`DHI_BUS_W-1:0]  host_data_bus_o,
  output wire                   host_data_bus_oe_o,
  input  wire [`DHI_BUS_W-1:0]  rd_word_i,
  input  wire                   pixel_clk_i,
  input  wire                   pixel_de_i,
  input  wire                   frame_sync_i,
  input  wire                   line_sync_i,
  output wire [`DHI_BUS_W-1:0]  word_o,
  output wire                   word_is_data_o,
  output wire                   word_is_pixel_o,
  output wire                   word_valid_o,
  input  wire                   word_ready_i,
  output wire                   wr_ready_o,
  output wire [8:0]             pixel_col_o,
  output wire [7:0]             pixel_row_o,
  output wire [2:0]             mode_o
);
  localparam NSYNC = 10;
  reg  [NSYNC-1:0]       s1_ff;
  reg  [NSYNC-1:0]       s2_ff;
  reg  [NSYNC-1:0]       s3_ff;
  reg  [NSYNC-1:0]       q_ff;
  reg  [NSYNC-1:0]       qd_ff;
  reg  [`DHI_BUS_W-1:0]  b1_ff;
  reg  [`DHI_BUS_W-1:0]  b2_ff;
  reg  [2:0]             mode_ff;
  reg                    strap_ff;
  reg  [17:0]            sh_ff;
  reg  [3:0]             bits_ff;
  reg                    s_dc_ff;
  reg  [8:0]             col_ff;
  reg  [7:0]             row_ff;
  reg  [`DHI_BUS_W-1:0]  rdo_ff;
  reg                    oe_ff;
  reg  [`DHI_BUS_W-1:0]  mask;
  reg  [19:0]            in_word;
  reg                    in_valid;
  reg  [17:0]            nxt_sh;
  wire [NSYNC-1:0]       raw;
  wire                   cs_n, wr_n, rd_n, sclk, sdat, pclk, de, fs, ls;
  wire                   wr_rise, sclk_rise, pclk_rise, ls_rise, fs_rise;
  wire                   serial, s4w, in_ready;
  integer                k;

  assign raw = {line_sync_i, frame_sync_i, pixel_de_i, pixel_clk_i,
                serial_data_i, data_cmd_sel_i, rd_n_i, wr_n_i, cs_n_i,
                1'b0};
  assign cs_n = q_ff[1];
  assign wr_n = q_ff[2];
  assign rd_n = q_ff[3];
  assign sclk = q_ff[4];
  assign sdat = q_ff[5];
  assign pclk = q_ff[6];
  assign de   = q_ff[7];
  assign fs   = q_ff[8];
  assign ls   = q_ff[9];
  assign wr_rise   = wr_n & ~qd_ff[2];
  assign sclk_rise = sclk & ~qd_ff[4];
  assign pclk_rise = pclk & ~qd_ff[6];
  assign fs_rise   = fs & ~qd_ff[8];
  assign ls_rise   = ls & ~qd_ff[9];
  assign serial = mode_ff[2];
  assign s4w    = (mode_ff == `DHI_MODE_S4W);

  // three-stage sync, change accepted when stages two and three agree
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_ff <= {NSYNC{1'b1}};
      s2_ff <= {NSYNC{1'b1}};
      s3_ff <= {NSYNC{1'b1}};
      q_ff  <= {NSYNC{1'b1}};
      qd_ff <= {NSYNC{1'b1}};
      b1_ff <= {`DHI_BUS_W{1'b0}};
      b2_ff <= {`DHI_BUS_W{1'b0}};
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      qd_ff <= q_ff;
      for (k = 0; k < NSYNC; k = k + 1) begin
        if (s2_ff[k] == s3_ff[k]) begin
          q_ff[k] <= s3_ff[k];
        end
      end
      b1_ff <= host_data_bus_i;
      b2_ff <= b1_ff;
    end
  end

  // straps caught once after reset release
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_ff <= 1'b0;
      mode_ff  <= `DHI_MODE_P8;
    end else if (!strap_ff) begin
      strap_ff <= 1'b1;
      mode_ff  <= {mode_sel_hi_i, mode_sel_mid_i, mode_sel_lo_i};
    end
  end

  always @* begin
    case (mode_ff)
      `DHI_MODE_P9:  mask = `DHI_MASK_P9;
      `DHI_MODE_P16: mask = `DHI_MASK_P16;
      `DHI_MODE_P18: mask = `DHI_MASK_P18;
      default:       mask = `DHI_MASK_P8;
    endcase
  end

  always @* begin
    nxt_sh = {sh_ff[16:0], sdat};
  end

  // word source mux: serial, pixel, parallel write
  always @* begin
    in_word  = 20'h00000;
    in_valid = 1'b0;
    if (serial) begin
      if (!cs_n && sclk_rise && strap_ff) begin
        if (s4w && bits_ff == `DHI_S4W_BITS - 4'h1) begin
          in_word  = {1'b0, q_ff[2], 10'h000, nxt_sh[7:0]};
          in_valid = 1'b1;
        end else if (!s4w && bits_ff == `DHI_S3W_BITS - 4'h1) begin
          in_word  = {1'b0, nxt_sh[8], 10'h000, nxt_sh[7:0]};
          in_valid = 1'b1;
        end
      end
    end else if (pclk_rise && de && strap_ff) begin
      in_word  = {1'b1, 1'b1, b2_ff & `DHI_MASK_P18};
      in_valid = 1'b1;
    end else if (!cs_n && wr_rise && strap_ff) begin
      in_word  = {1'b0, data_cmd_q(q_ff[4]), b2_ff & mask};
      in_valid = 1'b1;
    end
  end

  function data_cmd_q;
    input dc;
    begin
      data_cmd_q = dc;
    end
  endfunction

  // serial shifter and pixel position counters
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh_ff   <= 18'h00000;
      bits_ff <= 4'h0;
      s_dc_ff <= 1'b0;
      col_ff  <= 9'h000;
      row_ff  <= 8'h00;
    end else begin
      if (!serial || cs_n) begin
        bits_ff <= 4'h0;
      end else if (sclk_rise) begin
        sh_ff <= nxt_sh;
        if ((s4w && bits_ff == `DHI_S4W_BITS - 4'h1) ||
            (!s4w && bits_ff == `DHI_S3W_BITS - 4'h1)) begin
          bits_ff <= 4'h0;
        end else begin
          bits_ff <= bits_ff + 4'h1;
        end
        s_dc_ff <= q_ff[2];
      end
      if (fs_rise) begin
        row_ff <= 8'h00;
        col_ff <= 9'h000;
      end else if (ls_rise) begin
        col_ff <= 9'h000;
        if (row_ff != `DHI_ROWS - 8'h01) begin
          row_ff <= row_ff + 8'h01;
        end
      end else if (pclk_rise && de && !serial) begin
        if (col_ff != `DHI_COLS - 9'h001) begin
          col_ff <= col_ff + 9'h001;
        end
      end
    end
  end

  // read path drives the bus while chip select and the read strobe are low in a parallel mode
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdo_ff <= `DHI_RD_WORD_RST;
      oe_ff  <= 1'b0;
    end else begin
      oe_ff <= !serial && !cs_n && !rd_n && strap_ff;
      if (!rd_n && qd_ff[3]) begin
        rdo_ff <= rd_word_i & mask;
      end
    end
  end

  dhi_buf2 u_buf (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .in_data_i   (in_word),
    .in_valid_i  (in_valid),
    .in_ready_o  (in_ready),
    .out_data_o  ({word_is_pixel_o, word_is_data_o, word_o}),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i)
  );

  assign wr_ready_o         = in_ready;
  assign host_data_bus_o    = rdo_ff;
  assign host_data_bus_oe_o = oe_ff;
  assign pixel_col_o        = col_ff;
  assign pixel_row_o        = row_ff;
  assign mode_o             = mode_ff;
endmodule // dhi_host_if
`default_nettype wire

// ==== hdl/dhi_regs.vh ====
/*
 constants for the display host interface: mode codes, widths, sizes.
 assumes inclusion by the design files of the display host interface.
*/
`ifndef DHI_REGS_VH
`define DHI_REGS_VH
`define DHI_MODE_P8      3'h0
`define DHI_MODE_P16     3'h2
`define DHI_MODE_P9      3'h1
`define DHI_MODE_P18     3'h3
`define DHI_MODE_S3W     3'h5
`define DHI_MODE_S4W     3'h7
`define DHI_BUS_W        18
`define DHI_COLS         9'h140
`define DHI_ROWS         8'hF0
`define DHI_S3W_BITS     4'h9
`define DHI_S4W_BITS     4'h8
`define DHI_MASK_P8      18'h000FF
`define DHI_MASK_P9      18'h001FF
`define DHI_MASK_P16     18'h0FFFF
`define DHI_MASK_P18     18'h3FFFF
`define DHI_RD_WORD_RST  18'h00000
`endif

// ==== hdl/dhi_buf2.v ====
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module dhi_buf2 (
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  input  wire [19:0] in_data_i,
  input  wire        in_valid_i,
  output wire        in_ready_o,
  output wire [19:0] out_data_o,
  output wire        out_valid_o,
  input  wire        out_ready_i
);
  reg  [19:0] mem_ff [0:1];
  reg         wp_ff;
  reg         rp_ff;
  reg  [1:0]  cnt_ff;
  reg  [19:0] out_ff;
  wire        push;
  wire        pop;

  assign in_ready_o  = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = out_ff;

  always @(posedge ref_clk_i) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end

  // head word registered
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
      out_ff <= 20'h00000;
    end else begin
      if (push) begin
        wp_ff <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      if (pop && cnt_ff == 2'h2) begin
        out_ff <= mem_ff[~rp_ff];
      end else if (pop && push) begin
        out_ff <= in_data_i;
      end else if (!pop && push && cnt_ff == 2'h0) begin
        out_ff <= in_data_i;
      end
    end
  end
endmodule // dhi_buf2
`default_nettype wire

// ==== dv/dhi_host_if_asserts.sv ====
/*
 checker for the host interface word stream and read drive.
 assumes it is bound to dhi_host_if and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dhi_regs.vh"
module dhi_host_if_asserts (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic        cs_n_i,
  input wire logic        pixel_de_i,
  input wire logic        word_ready_i,
  input wire logic [17:0] word_o,
  input wire logic        word_is_data_o,
  input wire logic        word_is_pixel_o,
  input wire logic        word_valid_o,
  input wire logic        host_data_bus_oe_o,
  input wire logic [8:0]  pixel_col_o,
  input wire logic [7:0]  pixel_row_o,
  input wire logic [2:0]  mode_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  mode_hold_a: assert property (
    rstn_i && $past(rstn_i, 2) |-> $stable(mode_o)) else $error("mode moved");
  byte_width_a: assert property (
    word_valid_o && !word_is_pixel_o && mode_o == `DHI_MODE_P8
    |-> word_o[17:8] == 10'h000) else $error("byte word too wide");
  serial_width_a: assert property (
    word_valid_o && mode_o[2] |-> word_o[17:9] == 9'h000)
    else $error("serial word too wide");
  stall_hold_a: assert property (
    word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o)
    && $stable(word_is_data_o)) else $error("word lost in stall");
  oe_mode_a: assert property (
    host_data_bus_oe_o |-> !mode_o[2]) else $error("drive in serial mode");
  cs_gate_a: assert property (
    cs_n_i [*8] ##0 $rose(word_valid_o) |-> word_is_pixel_o)
    else $error("word without select");
  de_gate_a: assert property (
    !pixel_de_i [*8] ##0 $rose(word_valid_o) |-> !word_is_pixel_o)
    else $error("pixel without enable");
  pos_max_a: assert property (
    pixel_col_o <= 9'h13F && pixel_row_o <= 8'hEF) else $error("position");
  cover property (word_valid_o && word_ready_i && word_is_pixel_o);
  cover property (word_valid_o && !word_ready_i);
  cover property (host_data_bus_oe_o);
endmodule // dhi_host_if_asserts
`default_nettype wire

// ==== dv/dhi_host_model.sv ====
/*
 host model: parallel strobes, serial link and pixel port.
 assumes a 250 MHz ref_clk_i; link clocks run at 80 ns in frames.
*/
`timescale 1ns/1ns
`default_nettype none
module dhi_host_model (
  input  wire logic        ref_clk_i,
  output var  logic        cs_n_o,
  output var  logic        wr_n_o,
  output var  logic        rd_n_o,
  output var  logic        dc_o,
  output var  logic        sd_o,
  output var  logic [17:0] bus_o,
  output var  logic        pclk_o,
  output var  logic        de_o,
  output var  logic        fs_o
);
  initial begin
    {cs_n_o, wr_n_o, rd_n_o, dc_o, sd_o, pclk_o, de_o, fs_o} = 8'hE0;
    bus_o = 18'h00000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [17:0] d, input logic c, input logic s);
    cs_n_o = s;
    dc_o = c;
    bus_o = d;
    tick(8);
    wr_n_o = 1'b0;
    tick(8);
    wr_n_o = 1'b1;
    tick(8);
    bus_o = ~d;
    cs_n_o = 1'b1;
    tick(4);
  endtask
  task automatic rd_on(input logic v);
    cs_n_o = v;
    rd_n_o = v;
  endtask
  task automatic spi(input logic [8:0] d, input int n, input logic c);
    cs_n_o = 1'b0;
    wr_n_o = c;
    for (int i = n - 1; i >= 0; i--) begin
      sd_o = d[i];
      dc_o = 1'b0;
      tick(10);
      dc_o = 1'b1;
      tick(10);
    end
    dc_o = 1'b0;
    sd_o = ~sd_o;
    tick(10);
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    tick(4);
  endtask
  task automatic pix(input logic [17:0] d, input logic e, input logic f);
    bus_o = d;
    de_o = e;
    fs_o = f;
    pclk_o = 1'b0;
    tick(10);
    pclk_o = 1'b1;
    tick(10);
  endtask
endmodule // dhi_host_model
`default_nettype wire

// ==== dv/display_host_interface_tb.sv ====
/*
 testbench: host model drives pins, queue model checks the word stream.
 assumes dhi_host_if, dhi_host_model and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dhi_regs.vh"
module display_host_interface_tb;
  logic ref_clk_i = 0, rstn_i = 0, word_ready_i = 0, stall = 0;
  logic mode_sel_hi_i, mode_sel_mid_i, mode_sel_lo_i;
  int np = 0;
  logic cs_n_i, wr_n_i, rd_n_i, data_cmd_sel_i, serial_data_i;
  logic pixel_clk_i, pixel_de_i, frame_sync_i, host_data_bus_oe_o;
  logic word_is_data_o, word_is_pixel_o, word_valid_o, wr_ready_o;
  logic [17:0] hb, host_data_bus_i, host_data_bus_o, word_o, w;
  logic [17:0] rd_word_i;
  logic [19:0] e;
  logic [8:0] pixel_col_o;
  logic [7:0] pixel_row_o;
  logic [2:0] mode_o, md[4] = '{3'h0, 3'h1, 3'h2, 3'h3};
  int err_total = 0, check_count = 0, cyc = 0;
  logic [19:0] q[$];
  always #2 ref_clk_i = ~ref_clk_i;
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : hb;
  dhi_host_model u_h (.ref_clk_i, .cs_n_o(cs_n_i), .wr_n_o(wr_n_i),
    .rd_n_o(rd_n_i), .dc_o(data_cmd_sel_i), .sd_o(serial_data_i),
    .bus_o(hb), .pclk_o(pixel_clk_i), .de_o(pixel_de_i),
    .fs_o(frame_sync_i));
  dhi_host_if DUT (.ref_clk_i, .rstn_i, .mode_sel_hi_i, .mode_sel_mid_i,
    .mode_sel_lo_i, .cs_n_i, .wr_n_i, .rd_n_i, .data_cmd_sel_i,
    .serial_data_i, .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_o,
    .rd_word_i, .pixel_clk_i, .pixel_de_i, .frame_sync_i,
    .line_sync_i(frame_sync_i), .word_o, .word_is_data_o, .word_is_pixel_o,
    .word_valid_o, .word_ready_i, .wr_ready_o, .pixel_col_o, .pixel_row_o,
    .mode_o);
  task automatic chk(input string n, input logic [17:0] x, input logic [17:0] g);
    check_count++;
    if (x !== g) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    word_ready_i <= #1 stall ? 1'b0 : 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
    if (word_valid_o === 1'b1 && word_ready_i === 1'b1) begin
      e = q.size() ? q.pop_front() : 20'hFFFFF;
      chk("word", e[17:0], mode_o[2] ? word_o & 18'h000FF : word_o);
      chk("pixel", e[19], word_is_pixel_o);
      if (!e[19]) chk("is_data", e[18], word_is_data_o);
    end
  end
  function automatic logic [17:0] mk(input logic [2:0] m);
    case (m)
      `DHI_MODE_P8: mk = `DHI_MASK_P8;
      `DHI_MODE_P9: mk = `DHI_MASK_P9;
      `DHI_MODE_P16: mk = `DHI_MASK_P16;
      default: mk = `DHI_MASK_P18;
    endcase
  endfunction
  task automatic boot(input logic [2:0] m);
    u_h.tick(80);
    chk("drained", 18'(q.size()), 18'h00000);
    rstn_i = 1'b0;
    {mode_sel_hi_i, mode_sel_mid_i, mode_sel_lo_i} = m;
    u_h.tick(4);
    rstn_i = 1'b1;
    u_h.tick(4);
    chk("mode", 18'(m), 18'(mode_o));
  endtask
  task automatic pw(input logic c, input logic s);
    w = $urandom;
    if (wr_ready_o === 1'b1 && !s) q.push_back({1'b0, c, w & mk(mode_o)});
    u_h.wr(w, c, s);
  endtask
  initial begin
    void'($urandom(32'hFF7AB5DD));
    rd_word_i = $urandom;
    foreach (md[i]) begin
      boot(md[i]);
      repeat (6) pw(1'($urandom), 1'b0);
      pw(1'b1, 1'b1);
    end
    stall = 1'b1;
    repeat (2) pw(1'b1, 1'b0);
    chk("ready", 18'(wr_ready_o), 18'h00000);
    pw(1'b0, 1'b0);
    stall = 1'b0;
    rd_word_i = $urandom;
    u_h.rd_on(1'b0);
    u_h.tick(10);
    chk("read", rd_word_i, host_data_bus_i);
    chk("oe_on", 18'h00001, 18'(host_data_bus_oe_o));
    u_h.rd_on(1'b1);
    u_h.tick(10);
    chk("oe", 18'(host_data_bus_oe_o), 18'h00000);
    u_h.pix(18'h00000, 1'b0, 1'b1);
    repeat (8) begin
      w = $urandom;
      e[19] = 1'($urandom);
      if (e[19]) q.push_back({2'h2, w});
      if (e[19]) np++;
      u_h.pix(w, e[19], 1'b0);
    end
    chk("col", 18'(np), 18'(pixel_col_o));
    chk("row", 18'h00000, 18'(pixel_row_o));
    boot(`DHI_MODE_S4W);
    repeat (4) begin
      w = $urandom;
      q.push_back({1'b0, w[8], 10'h000, w[7:0]});
      u_h.spi(w[8:0], 8, w[8]);
    end
    boot(`DHI_MODE_S3W);
    repeat (4) begin
      w = $urandom;
      q.push_back({1'b0, w[8], 10'h000, w[7:0]});
      u_h.spi(w[8:0], 9, 1'b1);
    end
    boot(`DHI_MODE_S3W);
    close_out();
  end
endmodule // display_host_interface_tb
bind dhi_host_if dhi_host_if_asserts u_chk (.ref_clk_i, .rstn_i, .cs_n_i,
  .pixel_de_i, .word_ready_i, .word_o, .word_is_data_o, .word_is_pixel_o,
  .word_valid_o, .host_data_bus_oe_o, .pixel_col_o, .pixel_row_o, .mode_o);
`default_nettype wire
